//--- core/iaf_core.sv
// indirect data-memory addressing unit with the arithmetic flags register
// assumes a data memory that returns read data in the cycle after mem.rd
// Summary of operation
// R1: three 12-bit pointers, each held as a low and a high byte
// R2: access to a virtual location really touches memory at the pointer
// R3: indirect read landing on a virtual location returns 00h, sets zero
// R4: indirect write landing on a virtual location does nothing, flags kept
// R5: five virtual locations per pointer select how the pointer changes
// R6: post-decrement uses pointer, then subtracts one
// R7: post-increment uses pointer, then adds one
// R8: pre-increment adds one first and uses the new value
// R9: indexed adds signed working register; pointer and register unchanged
// R10: pointer steps never touch any arithmetic flag
// R11: steps act on all 12 bits, carrying between the bytes
// R12: a write to a pointer byte beats that pointer's own step
// R13: flags in bits 4..0 are N, OV, Z, DC, C; bits 7..5 read zero
// R14: flag bits updated by an instruction ignore direct writes that cycle
// R15: negative flag follows the result sign
// R16: overflow flag marks signed overflow into bit 7
// R17: zero flag set on a zero result, cleared otherwise
// R18: digit carry from bit 3 carry-out; rotates load it from bit 4 or 3
// R19: carry from bit 7 carry-out; rotates load it from the outgoing bit
// R20: subtraction adds the two's complement, so carries mean no borrow
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module iaf_core #(
    parameter int NPTR = iaf_pkg::PTR_COUNT
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire logic [11:0]         bus_addr,
    input  wire logic [7:0]          bus_wdata,
    input  wire logic                bus_wr,
    input  wire logic                bus_rd,
    output logic      [7:0]          bus_rdata,
    input  wire logic [7:0]          working_register,
    input  wire iaf_pkg::iaf_alu_t   alu,
    output iaf_pkg::iaf_mem_req_t    mem,
    input  wire logic [7:0]          mem_rdata,
    output logic      [7:0]          arith_flags
);
    import iaf_pkg::*;

    function automatic iaf_dec_t decode(input logic [11:0] a);
        iaf_dec_t d;
        d.idx = a[4:3];
        d.ofs = a[2:0];
        d.hit = (a[11:5] == PTR_BASE[11:5]) && (int'(a[4:3]) < NPTR);
        return d;
    endfunction

    function automatic logic is_virtual(input iaf_dec_t d);
        return d.hit && (d.ofs <= OFS_INDEXED);
    endfunction

    // R1: pointer storage, 12 bits each
    logic [11:0] mem_pointer      [NPTR];
    logic [11:0] next_mem_pointer [NPTR];
    logic [4:0]  flags;
    logic [4:0]  next_flags;
    logic        rd_local;
    logic [7:0]  rd_val;

    wire logic        acc_rd = ce && bus_rd;
    wire logic        acc_wr = ce && bus_wr;
    wire iaf_dec_t    dd     = decode(bus_addr);
    // R5: address of the access picks the pointer and its mode
    wire logic        via    = (acc_rd || acc_wr) && is_virtual(dd);
    wire logic [2:0]  mode   = dd.ofs;

    logic [11:0] cur;
    always_comb begin
        cur = PTR_RESET;
        for (int i = 0; i < NPTR; i++) begin
            if (int'(dd.idx) == i) begin
                cur = mem_pointer[i];
            end
        end
    end

    wire logic [11:0] sx_working_register  = {{4{working_register[7]}}, working_register};
    // R8: pre-increment address is the stepped value
    wire logic [11:0] pre_addr = cur + 12'h001;
    // R9: indexed address adds the signed working register
    wire logic [11:0] idx_addr = cur + sx_working_register;
    // R2: indirect access is redirected to the pointer contents
    wire logic [11:0] ea = !via ? bus_addr :
                           (mode == OFS_INDIRECT_LOC_C)  ? pre_addr :
                           (mode == OFS_INDEXED) ? idx_addr : cur;

    wire iaf_dec_t    td        = decode(ea);
    wire logic        tgt_null  = via && is_virtual(td);
    wire logic        tgt_flags = (ea == FLAGS_ADDR);
    wire logic        tgt_local = td.hit || tgt_flags || (ea[11:5] == PTR_BASE[11:5]);
    wire logic        null_rd   = acc_rd && tgt_null;
    wire logic        ptr_wr    = acc_wr && td.hit && (td.ofs == OFS_LOW || td.ofs == OFS_HIGH);

    // R4: a write landing on a virtual location reaches nothing
    assign mem.addr  = ea;
    assign mem.wdata = bus_wdata;
    assign mem.wr    = acc_wr && !tgt_local;
    assign mem.rd    = acc_rd && !tgt_local;

    generate
        for (genvar i = 0; i < NPTR; i++) begin : g_ptr
            wire logic wr_lo = ptr_wr && (int'(td.idx) == i) && (td.ofs == OFS_LOW);
            wire logic wr_hi = ptr_wr && (int'(td.idx) == i) && (td.ofs == OFS_HIGH);
            wire logic step  = via && (int'(dd.idx) == i);
            always_comb begin
                // R12: explicit byte write first, step only otherwise
                if (wr_lo) begin
                    next_mem_pointer[i] = {mem_pointer[i][11:8], bus_wdata};
                end else if (wr_hi) begin
                    next_mem_pointer[i] = {bus_wdata[3:0], mem_pointer[i][7:0]};
                end else if (step && mode == OFS_INDIRECT_LOC_A) begin
                    // R6: decrement after use; R11: full 12-bit borrow
                    next_mem_pointer[i] = mem_pointer[i] - 12'h001;
                end else if (step && (mode == OFS_INDIRECT_LOC_B || mode == OFS_INDIRECT_LOC_C)) begin
                    // R7/R8: increment, after use or before it for pre-increment; R11: full 12-bit carry
                    next_mem_pointer[i] = mem_pointer[i] + 12'h001;
                end else begin
                    next_mem_pointer[i] = mem_pointer[i];
                end
            end
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    mem_pointer[i] <= PTR_RESET;
                end else if (ce) begin
                    mem_pointer[i] <= next_mem_pointer[i];
                end
            end
        end
    endgenerate

    // local read value for pointer bytes and flags
    logic [11:0] tptr;
    always_comb begin
        tptr = PTR_RESET;
        for (int i = 0; i < NPTR; i++) begin
            if (int'(td.idx) == i) begin
                tptr = mem_pointer[i];
            end
        end
    end
    wire logic [7:0] local_val =
        tgt_null                           ? NULL_READ :
        tgt_flags                          ? {3'h0, flags} :
        (td.hit && td.ofs == OFS_LOW)      ? tptr[7:0] :
        (td.hit && td.ofs == OFS_HIGH)     ? {4'h0, tptr[11:8]} : NULL_READ;

    // flag arithmetic
    // R20: subtract as a plus inverted b plus one
    wire logic        is_sub = (alu.op == ALU_SUB);
    wire logic [7:0]  b_eff  = is_sub ? ~alu.b : alu.b;
    wire logic [8:0]  sum9   = {1'b0, alu.a} + {1'b0, b_eff} + {8'h00, is_sub};
    wire logic [4:0]  sum5   = {1'b0, alu.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub};
    wire logic [7:0]  ror_v  = {flags[FLAG_C], alu.a[7:1]};
    wire logic [7:0]  rol_v  = {alu.a[6:0], flags[FLAG_C]};
    wire logic        is_rot = (alu.op == ALU_ROR) || (alu.op == ALU_ROL);
    wire logic [7:0]  result = (alu.op == ALU_ADD || is_sub) ? sum9[7:0] :
                               (alu.op == ALU_ROR) ? ror_v :
                               (alu.op == ALU_ROL) ? rol_v : alu.res;
    wire logic [4:0]  alu_mask = (alu.op == ALU_ADD || is_sub) ? MASK_ARITH :
                                 is_rot ? MASK_ROTATE :
                                 (alu.op == ALU_LOGIC) ? MASK_LOGIC : MASK_NONE;
    logic [4:0] alu_flags;
    always_comb begin
        // R15: sign of result
        alu_flags[FLAG_N]  = result[7];
        // R16: operands agree in sign, result differs
        alu_flags[FLAG_OV] = (alu.a[7] == b_eff[7]) && (sum9[7] != alu.a[7]);
        // R17: zero detect
        alu_flags[FLAG_Z]  = (result == 8'h00);
        // R18: nibble carry, or bit 4 / bit 3 of the source on rotates
        alu_flags[FLAG_DC] = (alu.op == ALU_ROR) ? alu.a[4] :
                             (alu.op == ALU_ROL) ? alu.a[3] : sum5[4];
        // R19: carry out of bit 7, or the bit rotated out
        alu_flags[FLAG_C]  = (alu.op == ALU_ROR) ? alu.a[0] :
                             (alu.op == ALU_ROL) ? alu.a[7] : sum9[8];
    end

    // R14: bits the instruction computes are closed to the direct write
    wire logic [4:0] wsel = (acc_wr && tgt_flags && !tgt_null) ? ~alu_mask : MASK_NONE;
    wire logic [4:0] f_w  = (flags & ~wsel) | (bus_wdata[4:0] & wsel);
    // R3: null read raises zero unless the instruction computes it
    wire logic [4:0] f_z  = null_rd ? (f_w | 5'h04) : f_w;
    // R10: pointer steps do not feed this path
    wire logic [4:0] alu_upd = ce ? alu_mask : MASK_NONE;
    assign next_flags = (f_z & ~alu_upd) | (alu_flags & alu_upd);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flags <= FLAGS_RESET[4:0];
        end else if (ce) begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_local <= 1'b0;
            rd_val   <= NULL_READ;
        end else if (ce) begin
            rd_local <= acc_rd && tgt_local;
            rd_val   <= local_val;
        end
    end

    // memory data is already registered inside the memory
    assign bus_rdata = rd_local ? rd_val : mem_rdata;
    // R13: upper three bits unimplemented
    assign arith_flags = {3'h0, flags};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_quiet_alu;
        ce && alu.op == ALU_NONE;
    endsequence
    sequence s_step(logic [2:0] m);
        ce && via && mode == m && !ptr_wr;
    endsequence

    a_null_read_zero: assert property ( // R3
        (null_rd and s_quiet_alu) |=> (bus_rdata == NULL_READ) && arith_flags[FLAG_Z])
        else $error("null read not zero");
    a_null_write_quiet: assert property ( // R4
        (acc_wr && tgt_null) and s_quiet_alu |-> !mem.wr ##1 $stable(arith_flags))
        else $error("null write had effect");
    a_indirect_loc_a_step: assert property ( // R6
        s_step(OFS_INDIRECT_LOC_A) |-> mem.addr == cur ##1 mem_pointer[$past(dd.idx)] == 12'($past(cur) - 12'h001))
        else $error("post-decrement wrong");
    a_indirect_loc_b_step: assert property ( // R7
        s_step(OFS_INDIRECT_LOC_B) |-> mem.addr == cur ##1 mem_pointer[$past(dd.idx)] == 12'($past(cur) + 12'h001))
        else $error("post-increment wrong");
    a_indirect_loc_c_addr: assert property ( // R8
        s_step(OFS_INDIRECT_LOC_C) |-> mem.addr == 12'(cur + 12'h001) ##1 mem_pointer[$past(dd.idx)] == $past(mem.addr))
        else $error("pre-increment wrong");
    a_indexed_keep: assert property ( // R9
        s_step(OFS_INDEXED) |-> mem.addr == 12'(cur + sx_working_register) ##1 mem_pointer[$past(dd.idx)] == $past(cur))
        else $error("indexed access moved pointer");
    a_step_no_flags: assert property ( // R10
        (s_quiet_alu and (via && !tgt_null && !tgt_flags)) |=> $stable(arith_flags))
        else $error("step touched flags");
    a_write_wins: assert property ( // R12
        ce && ptr_wr && td.ofs == OFS_LOW && via && td.idx == dd.idx
        |=> mem_pointer[$past(td.idx)][7:0] == $past(bus_wdata))
        else $error("write lost to step");
    a_upper_zero: assert property ( // R13
        arith_flags[7:5] == 3'h0)
        else $error("unimplemented flag bits set");
    a_flag_write_blocked: assert property ( // R14
        ce && acc_wr && tgt_flags && alu.op == ALU_ADD |=> arith_flags[4:0] == $past(alu_flags))
        else $error("direct write beat arithmetic flags");
    a_sub_carry: assert property ( // R20
        ce && is_sub |=> arith_flags[FLAG_C] == ($past(alu.a) >= $past(alu.b)))
        else $error("subtract carry not inverted borrow");
endmodule
`default_nettype wire

//--- core/iaf_pkg.sv
// constants, types and address map of the indirect addressing and flags unit
// assumes one core clock; all addresses are 12-bit data-space byte addresses, offsets are 3-bit
package iaf_pkg;
    localparam int          AW           = 12;
    localparam int          DW           = 8;
    localparam int          PTR_COUNT    = 3;
    localparam logic [11:0] PTR_RESET    = 12'h000;
    localparam logic [7:0]  FLAGS_RESET  = 8'h00;
    localparam logic [7:0]  NULL_READ    = 8'h00;
    // register window: three pointer blocks of eight, then the flags byte
    localparam logic [11:0] PTR_BASE     = 12'hfe0;
    localparam logic [11:0] FLAGS_ADDR   = 12'hff8;
    localparam logic [2:0]  OFS_PLAIN    = 3'h0;
    localparam logic [2:0]  OFS_INDIRECT_LOC_A  = 3'h1;
    localparam logic [2:0]  OFS_INDIRECT_LOC_B  = 3'h2;
    localparam logic [2:0]  OFS_INDIRECT_LOC_C   = 3'h3;
    localparam logic [2:0]  OFS_INDEXED  = 3'h4;
    localparam logic [2:0]  OFS_LOW      = 3'h5;
    localparam logic [2:0]  OFS_HIGH     = 3'h6;
    // flag bit positions
    localparam int          FLAG_C       = 0;
    localparam int          FLAG_DC      = 1;
    localparam int          FLAG_Z       = 2;
    localparam int          FLAG_OV      = 3;
    localparam int          FLAG_N       = 4;
    localparam logic [4:0]  MASK_ARITH   = 5'h1f;
    localparam logic [4:0]  MASK_ROTATE  = 5'h17;
    localparam logic [4:0]  MASK_LOGIC   = 5'h14;
    localparam logic [4:0]  MASK_NONE    = 5'h00;

    typedef enum logic [2:0] {
        ALU_NONE  = 3'h0,
        ALU_ADD   = 3'h1,
        ALU_SUB   = 3'h2,
        ALU_LOGIC = 3'h3,
        ALU_ROR   = 3'h4,
        ALU_ROL   = 3'h5
    } iaf_alu_op_t;

    typedef struct packed {
        iaf_alu_op_t op;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [7:0]  res;
    } iaf_alu_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } iaf_mem_req_t;

    typedef struct packed {
        logic       hit;
        logic [1:0] idx;
        logic [2:0] ofs;
    } iaf_dec_t;
endpackage

//--- tb/iaf_core_tb_top.sv
// self-checking bench for iaf_core: pointers, null targets, flags
// assumes iaf_mem_model answers one cycle after each read strobe
`timescale 1ns/100ps
`default_nettype none
module iaf_core_tb_top;
    import iaf_pkg::*;
    logic         mclk = 0;
    logic         rst_n = 0;
    logic         ce = 1;
    logic [11:0]  bus_addr = 12'h000;
    logic [7:0]   bus_wdata = 8'h00;
    logic         bus_wr = 0;
    logic         bus_rd = 0;
    logic [7:0]   bus_rdata;
    logic [7:0]   working_register = 8'h00;
    iaf_alu_t     alu = '0;
    iaf_mem_req_t mem;
    logic [7:0]   mem_rdata;
    logic [7:0]   arith_flags;
    logic [7:0]   sh [4096];
    logic [4:0]   fl = 5'h00;
    logic [7:0]   expq [$];
    logic         rd_seen = 0;
    logic         rd_fl = 0;
    logic [7:0]   ev;
    int           fail_count = 0;
    int           samples_checked = 0;
    integer       seed = 9674;
    logic [7:0]   ra, rb, rr, w8;
    iaf_alu_op_t  ops [5] = '{ALU_ADD, ALU_SUB, ALU_LOGIC, ALU_ROR, ALU_ROL};

    always #20 mclk = ~mclk;

    iaf_core #(.NPTR(3)) i_iaf_core (.mclk(mclk), .rst_n(rst_n), .ce(ce), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .working_register(working_register), .alu(alu), .mem(mem), .mem_rdata(mem_rdata),
        .arith_flags(arith_flags));
    iaf_mem_model i_iaf_mem_model (.mclk(mclk), .req(mem), .rdata(mem_rdata));

    task automatic acc(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d,
                       input iaf_alu_t al);
        @(posedge mclk);
        bus_wr <= w;
        bus_rd <= r;
        bus_addr <= a;
        bus_wdata <= d;
        alu <= al;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d, '0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        acc(1'b0, 1'b1, a, 8'h00, '0);
        expq.push_back(e);
    endtask
    // expected flags after one alu op; subtract adds the inverted operand plus one
    task automatic calc(input iaf_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                        input logic [7:0] res);
        logic [7:0] bb;
        logic       cin;
        logic [8:0] s;
        logic [7:0] r;
        cin = (op == ALU_SUB);
        bb = cin ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
        r = res;
        if (op == ALU_ADD || op == ALU_SUB) begin
            r = s[7:0];
            fl[FLAG_C] = s[8];
            fl[FLAG_DC] = ({1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin}) > 5'h0f;
            fl[FLAG_OV] = (a[7] == bb[7]) && (r[7] != a[7]);
        end else if (op == ALU_ROR) begin
            r = {fl[FLAG_C], a[7:1]};
            fl[FLAG_C] = a[0];
            fl[FLAG_DC] = a[4];
        end else if (op == ALU_ROL) begin
            r = {a[6:0], fl[FLAG_C]};
            fl[FLAG_C] = a[7];
            fl[FLAG_DC] = a[3];
        end
        fl[FLAG_N] = r[7];
        fl[FLAG_Z] = (r == 8'h00);
    endtask
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge mclk) rd_seen <= bus_rd;
    always @(posedge mclk) rd_fl <= bus_rd && (bus_addr == FLAGS_ADDR);
    always @(negedge mclk) begin
        if (rd_seen) begin
            ev = expq.pop_front();
            check("bus_rdata", ev, bus_rdata);
            if (rd_fl) begin
                check("arith_flags", ev, arith_flags);
            end
        end
    end

    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end

    initial begin
        for (int i = 0; i < 4096; i++) sh[i] = i[7:0] ^ 8'h3c;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd(FLAGS_ADDR, 8'h00);
        rd(12'hfe6, 8'h00);
        wr(12'hfe5, 8'hff);
        wr(12'hfe6, 8'h00);
        rd(12'hfe2, sh[12'h0ff]);
        rd(12'hfe6, 8'h01);
        rd(12'hfe5, 8'h00);
        rd(12'hfe1, sh[12'h100]);
        rd(12'hfe5, 8'hff);
        rd(12'hfe3, sh[12'h100]);
        w8 = $random(seed);
        working_register <= w8;
        rd(12'hfe4, sh[12'h100 + {{4{w8[7]}}, w8}]);
        rd(12'hfe5, 8'h00);
        ra = $random(seed);
        wr(12'hfe0, ra);
        sh[12'h100] = ra;
        rd(12'hfe0, ra);
        wr(12'hfed, 8'he0);
        wr(12'hfee, 8'h0f);
        wr(FLAGS_ADDR, 8'h00);
        rd(12'hfe8, 8'h00);
        rd(FLAGS_ADDR, 8'h04);
        wr(FLAGS_ADDR, 8'h0b);
        fl = 5'h0b;
        wr(12'hfe8, 8'h00);
        rd(FLAGS_ADDR, 8'h0b);
        wr(12'hff5, 8'h01);
        wr(12'hff6, 8'h00);
        rd(12'hff1, sh[12'h001]);
        rd(12'hff5, 8'h00);
        rd(FLAGS_ADDR, 8'h0b);
        rd(12'hff1, sh[12'h000]);
        rd(12'hff6, 8'h0f);
        wr(12'hfe5, 8'he5);
        wr(12'hfe6, 8'h0f);
        wr(12'hfe2, 8'h33);
        rd(12'hfe5, 8'h33);
        rd(12'hfe6, 8'h0f);
        // clock enable low: the write must not land
        wr(12'hfe5, 8'h77);
        ce <= 1'b0;
        acc(1'b0, 1'b0, 12'h000, 8'h00, '0);
        ce <= 1'b1;
        rd(12'hfe5, 8'h33);
        wr(FLAGS_ADDR, 8'hff);
        fl = 5'h1f;
        rd(FLAGS_ADDR, 8'h1f);
        calc(ALU_ADD, 8'h80, 8'h80, 8'h00);
        acc(1'b1, 1'b0, FLAGS_ADDR, 8'he0, '{ALU_ADD, 8'h80, 8'h80, 8'h00});
        rd(FLAGS_ADDR, {3'b000, fl});
        for (int i = 0; i < 25; i++) begin
            ra = $random(seed);
            rb = $random(seed);
            rr = $random(seed);
            calc(ops[i % 5], ra, rb, rr);
            acc(1'b0, 1'b0, 12'h000, 8'h00, '{ops[i % 5], ra, rb, rr});
            rd(FLAGS_ADDR, {3'b000, fl});
        end
        repeat (3) acc(1'b0, 1'b0, 12'h000, 8'h00, '0);
        wrap_up();
    end
endmodule
`default_nettype wire

//--- tb/iaf_mem_model.sv
// behavioural data memory facing iaf_core
// assumes read data are wanted only in the cycle after a read strobe
`timescale 1ns/100ps
`default_nettype none
module iaf_mem_model
    import iaf_pkg::*;
(
    input  wire logic                  mclk,
    input  wire iaf_pkg::iaf_mem_req_t req,
    output logic [7:0]                 rdata = 8'h00
);
    logic [7:0] m [4096];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            m[i] = i[7:0] ^ 8'h3c;
        end
    end
    // toggles outside the answer cycle so stale data never looks valid
    always @(posedge mclk) begin
        if (req.wr) begin
            m[req.addr] <= req.wdata;
        end
        if (req.rd) begin
            rdata <= m[req.addr];
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule
`default_nettype wire
